// ==== src/tmr_timer8.sv ====
// 8-bit timer/counter with two compare channels and an apb slave
// ---------------------------------------------------------------
// Notes on behaviour
// - each tick clears, increments or decrements counter
// - clock source zero stops all ticks
// - counter readable and writable at any time
// - processor counter write beats count or clear
// - three-bit mode split across control a and b
// - overflow flag set per mode, raises interrupt
// - comparator flags equality per channel
// - match sets flag on following tick
// - flag cleared by service or writing one
// - pwm modes buffer compare, load at top/bottom
// - normal and clear-on-match write compare directly
// - force strobe acts like match outside pwm modes, no flag
// - counter write blocks matches on next tick
// - output action bits take effect immediately
// - reset clears both wave output states
// - nonzero action overrides port pin output
// - action zero leaves output state unchanged
// - action bits never alter counting sequence
// - pwm inverts or not, or toggles; others set/clear/toggle
// - wave states kept across mode changes
// - bottom is zero, max is ff
// - normal mode wraps and flags overflow at zero
// - clear-on-match mode uses compare a as top
// - fast pwm top ff or compare a
// ---------------------------------------------------------------
`timescale 1ns/1ps
`include "tmr_consts.svh"
module tmr_timer8
  import tmr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        extTick,
  input  wire logic        irqAckOvf,
  input  wire logic        irqAckA,
  input  wire logic        irqAckB,
  output logic             irqOvf,
  output logic             irqA,
  output logic             irqB,
  output logic             waveOutAOut,
  output logic             waveOutAOe,
  output logic             waveOutBOut,
  output logic             waveOutBOe
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  tmr_ctrl_s  ctrl,        next_ctrl;
  tmr_flags_s flags,       next_flags;
  logic [2:0] imask,       next_imask;
  logic [7:0] counterValue, next_counterValue;
  logic [7:0] cmpA,        next_cmpA;
  logic [7:0] cmpB,        next_cmpB;
  logic [7:0] bufA,        next_bufA;
  logic [7:0] bufB,        next_bufB;
  logic       waveA,       next_waveA;
  logic       waveB,       next_waveB;
  logic       countDown,   next_countDown;
  logic       blockMatch,  next_blockMatch;
  logic       matchPendA,  next_matchPendA;
  logic       matchPendB,  next_matchPendB;
  logic [1:0] portOut,     next_portOut;
  logic [1:0] portDir,     next_portDir;
  logic       tickSync1,   tickSync2,  tickSync3;
  logic [31:0] next_prdata;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic       wrEn;
  logic       rdEn;
  logic       known;
  logic       tick;
  logic       pwmMode;
  logic       dualSlope;
  logic [7:0] topValue;
  logic       atTop;
  logic       atBottom;
  logic       eqA;
  logic       eqB;
  logic       matchA;
  logic       matchB;
  logic       wrCount;

  assign wrEn    = psel && penable && pwrite;
  assign rdEn    = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !known;
  assign wrCount = wrEn && (paddr == `TMR_OFF_COUNT);

  always_comb
  begin
    unique case (paddr)
      `TMR_OFF_CTRLA, `TMR_OFF_CTRLB, `TMR_OFF_CTRLC, `TMR_OFF_COUNT,
      `TMR_OFF_CMPA, `TMR_OFF_CMPB, `TMR_OFF_FLAGS, `TMR_OFF_IMASK,
      `TMR_OFF_PORT, `TMR_OFF_DIR, `TMR_OFF_TICK: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // external tick arrives from a pin: two flops then edge detect
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tickSync1 <= 1'b0;
      tickSync2 <= 1'b0;
      tickSync3 <= 1'b0;
    end
    else
    begin
      tickSync1 <= extTick;
      tickSync2 <= tickSync1;
      tickSync3 <= tickSync2;
    end
  end

  // tick is a one-cycle enable; zero source stops it
  always_comb
  begin
    unique case (ctrl.clockSourceSelect)
      `TMR_CS_STOP: tick = 1'b0;
      `TMR_CS_SYS:  tick = 1'b1;
      default:      tick = tickSync2 && !tickSync3;
    endcase
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  always_comb
  begin
    pwmMode   = ctrl.waveMode[0];
    dualSlope = (ctrl.waveMode == `TMR_WGM_PCMAX) || (ctrl.waveMode == `TMR_WGM_PCTOP);
    if (ctrl.waveMode[2] || ctrl.waveMode == `TMR_WGM_CTC)
      topValue = cmpA;
    else
      topValue = `TMR_MAX;
  end

  assign atTop    = (counterValue == topValue);
  assign atBottom = (counterValue == `TMR_BOTTOM);
  assign eqA      = (counterValue == cmpA);
  assign eqB      = (counterValue == cmpB);
  assign matchA   = tick && eqA && !blockMatch;
  assign matchB   = tick && eqB && !blockMatch;

  // ---------------------------------------------------------------
  // counter, compare and flags
  // ---------------------------------------------------------------
  always_comb
  begin
    next_ctrl         = ctrl;
    next_imask        = imask;
    next_flags        = flags;
    next_counterValue = counterValue;
    next_cmpA         = cmpA;
    next_cmpB         = cmpB;
    next_bufA         = bufA;
    next_bufB         = bufB;
    next_countDown    = countDown;
    next_portOut      = portOut;
    next_portDir      = portDir;
    next_blockMatch   = blockMatch;
    next_matchPendA   = matchPendA;
    next_matchPendB   = matchPendB;
    if (wrCount)
      next_blockMatch = 1'b1;
    else if (tick)
      next_blockMatch = 1'b0;
    // count sequence depends only on the mode field and, as top, compare a
    if (tick)
    begin
      if (dualSlope)
      begin
        if (atTop)
        begin
          next_countDown    = 1'b1;
          next_counterValue = counterValue - 8'h01;
        end
        else if (atBottom && countDown)
        begin
          next_countDown    = 1'b0;
          next_counterValue = counterValue + 8'h01;
        end
        else if (countDown)
          next_counterValue = counterValue - 8'h01;
        else
          next_counterValue = counterValue + 8'h01;
      end
      else if (ctrl.waveMode != `TMR_WGM_NORMAL && atTop)
      begin
        next_countDown    = 1'b0;
        next_counterValue = `TMR_BOTTOM;
      end
      else
      begin
        next_countDown    = 1'b0;
        next_counterValue = counterValue + 8'h01;
      end
    end
    // overflow: at wrap to zero, at top in fast pwm, at bottom in dual slope
    if (tick && ((!pwmMode && counterValue == `TMR_MAX)
                 || (pwmMode && !dualSlope && atTop)
                 || (dualSlope && atBottom && countDown)))
      next_flags.ovf = 1'b1;
    else if (irqAckOvf || (wrEn && paddr == `TMR_OFF_FLAGS && pwdata[`TMR_FLG_OVF]))
      next_flags.ovf = 1'b0;
    // match flags set on the tick after the match
    if (tick)
    begin
      next_matchPendA = matchA;
      next_matchPendB = matchB;
    end
    if (tick && matchPendA)
      next_flags.cmpA = 1'b1;
    else if (irqAckA || (wrEn && paddr == `TMR_OFF_FLAGS && pwdata[`TMR_FLG_CMPA]))
      next_flags.cmpA = 1'b0;
    if (tick && matchPendB)
      next_flags.cmpB = 1'b1;
    else if (irqAckB || (wrEn && paddr == `TMR_OFF_FLAGS && pwdata[`TMR_FLG_CMPB]))
      next_flags.cmpB = 1'b0;
    // double buffered compare values in pwm modes
    if (pwmMode && tick && (dualSlope ? atTop : atBottom))
    begin
      next_cmpA = bufA;
      next_cmpB = bufB;
    end
    if (wrEn)
    begin
      unique case (paddr)
        `TMR_OFF_CTRLA:
        begin
          next_ctrl.actionA      = pwdata[7:6];
          next_ctrl.actionB      = pwdata[5:4];
          next_ctrl.waveMode[1:0] = pwdata[1:0];
        end
        `TMR_OFF_CTRLB:
        begin
          next_ctrl.waveMode[2]       = pwdata[3];
          next_ctrl.clockSourceSelect = pwdata[2:0];
        end
        `TMR_OFF_COUNT: next_counterValue = pwdata[7:0];
        `TMR_OFF_CMPA:
        begin
          next_bufA = pwdata[7:0];
          if (!pwmMode)
            next_cmpA = pwdata[7:0];
        end
        `TMR_OFF_CMPB:
        begin
          next_bufB = pwdata[7:0];
          if (!pwmMode)
            next_cmpB = pwdata[7:0];
        end
        `TMR_OFF_IMASK: next_imask   = pwdata[2:0];
        `TMR_OFF_PORT:  next_portOut = pwdata[1:0];
        `TMR_OFF_DIR:   next_portDir = pwdata[1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // wave output state
  // ---------------------------------------------------------------
  function automatic logic waveNext(input logic cur, input logic [1:0] act,
                                    input logic pwm, input logic dual,
                                    input logic down, input logic hit,
                                    input logic bottomHit);
    logic r;
    r = cur;
    if (act == `TMR_COM_NONE)
      r = cur;
    else if (!pwm || act == `TMR_COM_TOGGLE)
    begin
      if (hit)
        r = (act == `TMR_COM_TOGGLE) ? !cur : (act == `TMR_COM_SET);
    end
    else if (dual)
    begin
      if (hit)
        r = (act == `TMR_COM_SET) ^ down;
    end
    else if (hit)
      r = (act == `TMR_COM_SET);
    else if (bottomHit)
      r = (act == `TMR_COM_CLEAR);
    return r;
  endfunction

  logic forceA;
  logic forceB;
  logic wrapTick;
  assign forceA   = wrEn && paddr == `TMR_OFF_CTRLC && pwdata[7] && !pwmMode;
  assign forceB   = wrEn && paddr == `TMR_OFF_CTRLC && pwdata[6] && !pwmMode;
  assign wrapTick = tick && pwmMode && !dualSlope && atTop;

  always_comb
  begin
    next_waveA = waveNext(waveA, ctrl.actionA, pwmMode, dualSlope, countDown,
                          matchA || forceA, wrapTick);
    next_waveB = waveNext(waveB, ctrl.actionB, pwmMode, dualSlope, countDown,
                          matchB || forceB, wrapTick);
  end

  // ---------------------------------------------------------------
  // readback
  // ---------------------------------------------------------------
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (rdEn)
    begin
      unique case (paddr)
        `TMR_OFF_CTRLA: next_prdata = {24'h0, ctrl.actionA, ctrl.actionB, 2'h0,
                                       ctrl.waveMode[1:0]};
        `TMR_OFF_CTRLB: next_prdata = {28'h0, ctrl.waveMode[2], ctrl.clockSourceSelect};
        `TMR_OFF_COUNT: next_prdata = {24'h0, counterValue};
        `TMR_OFF_CMPA:  next_prdata = {24'h0, pwmMode ? bufA : cmpA};
        `TMR_OFF_CMPB:  next_prdata = {24'h0, pwmMode ? bufB : cmpB};
        `TMR_OFF_FLAGS: next_prdata = {29'h0, flags.cmpB, flags.cmpA, flags.ovf};
        `TMR_OFF_IMASK: next_prdata = {29'h0, imask};
        `TMR_OFF_PORT:  next_prdata = {30'h0, portOut};
        `TMR_OFF_DIR:   next_prdata = {30'h0, portDir};
        `TMR_OFF_TICK:  next_prdata = {29'h0, countDown, waveB, waveA};
        default:        next_prdata = 32'h0000_0000;
      endcase
    end
  end
  assign prdata = next_prdata;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ctrl         <= '0;
      flags        <= '0;
      imask        <= 3'h0;
      counterValue <= 8'h00;
      cmpA         <= 8'h00;
      cmpB         <= 8'h00;
      bufA         <= 8'h00;
      bufB         <= 8'h00;
      waveA        <= 1'b0;
      waveB        <= 1'b0;
      countDown    <= 1'b0;
      blockMatch   <= 1'b0;
      matchPendA   <= 1'b0;
      matchPendB   <= 1'b0;
      portOut      <= 2'h0;
      portDir      <= 2'h0;
    end
    else
    begin
      ctrl         <= next_ctrl;
      flags        <= next_flags;
      imask        <= next_imask;
      counterValue <= next_counterValue;
      cmpA         <= next_cmpA;
      cmpB         <= next_cmpB;
      bufA         <= next_bufA;
      bufB         <= next_bufB;
      waveA        <= next_waveA;
      waveB        <= next_waveB;
      countDown    <= next_countDown;
      blockMatch   <= next_blockMatch;
      matchPendA   <= next_matchPendA;
      matchPendB   <= next_matchPendB;
      portOut      <= next_portOut;
      portDir      <= next_portDir;
    end
  end

  // ---------------------------------------------------------------
  // pins and interrupts
  // ---------------------------------------------------------------
  assign waveOutAOut = (ctrl.actionA != `TMR_COM_NONE) ? waveA : portOut[0];
  assign waveOutBOut = (ctrl.actionB != `TMR_COM_NONE) ? waveB : portOut[1];
  assign waveOutAOe  = portDir[0];
  assign waveOutBOe  = portDir[1];
  assign irqOvf      = flags.ovf && imask[`TMR_FLG_OVF];
  assign irqA        = flags.cmpA && imask[`TMR_FLG_CMPA];
  assign irqB        = flags.cmpB && imask[`TMR_FLG_CMPB];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_stopped;
    @(posedge clk_sys) disable iff (!rst_n)
      (ctrl.clockSourceSelect == `TMR_CS_STOP && !wrEn) |=> $stable(counterValue);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

  property p_wrprio;
    @(posedge clk_sys) disable iff (!rst_n)
      wrCount |=> counterValue == $past(pwdata[7:0]);
  endproperty
  a_wrprio: assert property (p_wrprio) else $error("counter write lost");

  property p_cmpflag;
    @(posedge clk_sys) disable iff (!rst_n)
      (tick && matchPendA) |=> flags.cmpA;
  endproperty
  a_cmpflag: assert property (p_cmpflag) else $error("compare flag a not set");

  property p_block;
    @(posedge clk_sys) disable iff (!rst_n)
      wrCount |=> !matchA && !matchB;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked after write");

  property p_normwrap;
    @(posedge clk_sys) disable iff (!rst_n)
      (tick && !wrEn && ctrl.waveMode == `TMR_WGM_NORMAL && counterValue == `TMR_MAX)
        |=> counterValue == `TMR_BOTTOM && flags.ovf;
  endproperty
  a_normwrap: assert property (p_normwrap) else $error("normal wrap wrong");

  property p_ctcclear;
    @(posedge clk_sys) disable iff (!rst_n)
      (tick && !wrEn && ctrl.waveMode == `TMR_WGM_CTC && eqA) |=> counterValue == `TMR_BOTTOM;
  endproperty
  a_ctcclear: assert property (p_ctcclear) else $error("ctc did not clear");

  property p_none;
    @(posedge clk_sys) disable iff (!rst_n)
      (ctrl.actionA == `TMR_COM_NONE) |=> waveA == $past(waveA);
  endproperty
  a_none: assert property (p_none) else $error("wave a changed with no action");

  property p_direct;
    @(posedge clk_sys) disable iff (!rst_n)
      (wrEn && paddr == `TMR_OFF_CMPA && !pwmMode) |=> cmpA == $past(pwdata[7:0]);
  endproperty
  a_direct: assert property (p_direct) else $error("direct compare write lost");

endmodule

// ==== src/tmr_consts.svh ====
// constants for the 8-bit timer/counter: offsets, fields, count limits and encodings
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
`define TMR_OFF_CTRLA   12'h000
`define TMR_OFF_CTRLB   12'h004
`define TMR_OFF_CTRLC   12'h008
`define TMR_OFF_COUNT   12'h00c
`define TMR_OFF_CMPA    12'h010
`define TMR_OFF_CMPB    12'h014
`define TMR_OFF_FLAGS   12'h018
`define TMR_OFF_IMASK   12'h01c
`define TMR_OFF_PORT    12'h020
`define TMR_OFF_DIR     12'h024
`define TMR_OFF_TICK    12'h028
`define TMR_BOTTOM      8'h00
`define TMR_MAX         8'hff
`define TMR_FLG_OVF     0
`define TMR_FLG_CMPA    1
`define TMR_FLG_CMPB    2
`define TMR_CS_STOP     3'h0
`define TMR_CS_SYS      3'h1
`define TMR_WGM_NORMAL  3'h0
`define TMR_WGM_PCMAX   3'h1
`define TMR_WGM_CTC     3'h2
`define TMR_WGM_FASTMAX 3'h3
`define TMR_WGM_PCTOP   3'h5
`define TMR_WGM_FASTTOP 3'h7
`define TMR_COM_NONE    2'h0
`define TMR_COM_TOGGLE  2'h1
`define TMR_COM_CLEAR   2'h2
`define TMR_COM_SET     2'h3
`endif

// ==== src/tmr_pkg.sv ====
// types for the 8-bit timer/counter
package tmr_pkg;
  typedef struct packed {
    logic [1:0] actionA;
    logic [1:0] actionB;
    logic [2:0] waveMode;
    logic [2:0] clockSourceSelect;
  } tmr_ctrl_s;
  typedef struct packed {
    logic ovf;
    logic cmpA;
    logic cmpB;
  } tmr_flags_s;
endpackage

// ==== bench/tmr_apb_host.sv ====
// apb master model standing in for the processor core
`timescale 1ns/1ps
module tmr_apb_host (
  input  wire logic        clk_sys,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  logic hung;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    hung = 1'b0;
  end
  // setup, access held until pready, then release with the lines inverted
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    hung = (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ==== bench/timer8_counter_compare_output_test.sv ====
// self-checking bench for the 8-bit timer/counter
`timescale 1ns/1ps
`include "tmr_consts.svh"
module timer8_counter_compare_output_test
  import tmr_pkg::*;
;
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, extTick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        ackOvf, ackA, ackB, irqOvf, irqA, irqB, aOut, aOe, bOut, bOe;
  int          nErrors, checksDone;

  tmr_timer8 tmr_timer8_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .extTick(extTick),
    .irqAckOvf(ackOvf), .irqAckA(ackA), .irqAckB(ackB), .irqOvf(irqOvf),
    .irqA(irqA), .irqB(irqB), .waveOutAOut(aOut), .waveOutAOe(aOe),
    .waveOutBOut(bOut), .waveOutBOe(bOe));
  tmr_apb_host tmr_apb_host_i (.clk_sys(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // -------------------------
  // helpers
  // -------------------------
  task automatic giveVerdict();
    $display("errors %0d checks %0d", nErrors, checksDone);
    if (nErrors == 0 && checksDone > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp)
    begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    tmr_apb_host_i.xfer(w, a, d, r, e);
    if (tmr_apb_host_i.hung)
    begin
      nErrors++;
      $display("MISMATCH pready expected 1 seen 0");
      giveVerdict();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    bus(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic        e;
    bus(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
  endtask
  // sel: 0 overflow irq, 1 irq a, 2 irq b
  task automatic waitHigh(input int sel, input string what);
    logic v;
    v = (sel == 0) ? irqOvf : (sel == 1) ? irqA : irqB;
    for (int i = 0; i < 400 && v !== 1'b1; i++)
    begin
      @(posedge clk_sys);
      v = (sel == 0) ? irqOvf : (sel == 1) ? irqA : irqB;
    end
    chk(what, 32'h1, {31'h0, v});
    if (v !== 1'b1)
      giveVerdict();
  endtask

  // -------------------------
  // scenarios
  // -------------------------
  task automatic scnReset();
    logic [31:0] r;
    logic        e;
    rd(`TMR_OFF_COUNT, 32'h0, "counter");
    rd(`TMR_OFF_TICK, 32'h0, "wave states");
    bus(1'b0, 12'h0fc, 32'h0, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    wr(`TMR_OFF_COUNT, 32'h5a);
    repeat (10) @(posedge clk_sys);
    rd(`TMR_OFF_COUNT, 32'h5a, "stopped counter");
  endtask
  task automatic scnOverflow();
    logic [31:0] r;
    logic        e;
    wr(`TMR_OFF_IMASK, 32'h1);
    wr(`TMR_OFF_COUNT, 32'hf8);
    wr(`TMR_OFF_CTRLB, 32'h1);
    waitHigh(0, "overflow irq");
    rd(`TMR_OFF_FLAGS, 32'h7, "overflow and zero-compare flags");
    wr(`TMR_OFF_COUNT, 32'h10);
    wr(`TMR_OFF_CTRLB, 32'h0);
    bus(1'b0, `TMR_OFF_COUNT, 32'h0, r, e);
    chk("written count", 32'h1, {31'h0, r >= 32'h11 && r <= 32'h14});
    ackOvf <= 1'b1;
    @(posedge clk_sys);
    ackOvf <= 1'b0;
    #1 chk("overflow irq serviced", 32'h0, {31'h0, irqOvf});
  endtask
  task automatic scnCompare();
    wr(`TMR_OFF_FLAGS, 32'h7);
    wr(`TMR_OFF_IMASK, 32'h6);
    wr(`TMR_OFF_CMPA, 32'h20);
    wr(`TMR_OFF_CMPB, 32'h24);
    wr(`TMR_OFF_COUNT, 32'h18);
    wr(`TMR_OFF_CTRLB, 32'h1);
    waitHigh(1, "irq a");
    ackA <= 1'b1;
    @(posedge clk_sys);
    ackA <= 1'b0;
    #1 chk("irq a serviced", 32'h0, {31'h0, irqA});
    waitHigh(2, "irq b");
    wr(`TMR_OFF_FLAGS, 32'h4);
    #1 chk("irq b cleared", 32'h0, {31'h0, irqB});
    wr(`TMR_OFF_CTRLB, 32'h0);
  endtask
  task automatic scnForce();
    logic [1:0] act [4] = '{`TMR_COM_SET, `TMR_COM_CLEAR, `TMR_COM_TOGGLE, `TMR_COM_NONE};
    logic       st [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    wr(`TMR_OFF_FLAGS, 32'h7);
    wr(`TMR_OFF_COUNT, 32'h77);
    for (int i = 0; i < 4; i++)
    begin
      wr(`TMR_OFF_CTRLA, {24'h0, act[i], 6'h0});
      wr(`TMR_OFF_CTRLC, 32'h80);
      rd(`TMR_OFF_TICK, {31'h0, st[i]}, "wave a state");
    end
    rd(`TMR_OFF_FLAGS, 32'h0, "flags after force");
    rd(`TMR_OFF_COUNT, 32'h77, "count after force");
    wr(`TMR_OFF_PORT, 32'h0);
    wr(`TMR_OFF_CTRLA, 32'h40);
    wr(`TMR_OFF_DIR, 32'h1);
    #1 chk("pin a", 32'h1, {31'h0, aOut});
    chk("pin a dir", 32'h1, {31'h0, aOe});
    wr(`TMR_OFF_CTRLA, 32'h0);
    #1 chk("pin a port", 32'h0, {31'h0, aOut});
    wr(`TMR_OFF_CTRLA, 32'h3);
    rd(`TMR_OFF_TICK, 32'h1, "state after mode change");
    wr(`TMR_OFF_CTRLA, 32'h0);
  endtask
  task automatic scnBlock();
    wr(`TMR_OFF_CMPB, 32'h40);
    wr(`TMR_OFF_FLAGS, 32'h7);
    wr(`TMR_OFF_COUNT, 32'h40);
    wr(`TMR_OFF_CTRLB, 32'h1);
    repeat (6) @(posedge clk_sys);
    wr(`TMR_OFF_CTRLB, 32'h0);
    rd(`TMR_OFF_FLAGS, 32'h0, "blocked match");
  endtask
  task automatic scnCtc();
    logic [31:0] r;
    logic        e;
    wr(`TMR_OFF_CTRLA, {30'h0, `TMR_WGM_CTC} & 32'h3);
    wr(`TMR_OFF_CMPA, 32'h05);
    rd(`TMR_OFF_CMPA, 32'h05, "direct compare a");
    wr(`TMR_OFF_COUNT, 32'h00);
    wr(`TMR_OFF_CTRLB, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, `TMR_OFF_COUNT, 32'h0, r, e);
      chk("count under top", 32'h1, {31'h0, r <= 32'h05});
    end
    wr(`TMR_OFF_CTRLB, 32'h0);
    wr(`TMR_OFF_CTRLA, 32'h0);
  endtask
  task automatic scnBuffer();
    wr(`TMR_OFF_CMPA, 32'hf0);
    wr(`TMR_OFF_CTRLA, 32'h3);
    wr(`TMR_OFF_CMPA, 32'h52);
    rd(`TMR_OFF_CMPA, 32'h52, "buffer read");
    wr(`TMR_OFF_COUNT, 32'h50);
    wr(`TMR_OFF_FLAGS, 32'h7);
    wr(`TMR_OFF_CTRLB, 32'h1);
    repeat (8) @(posedge clk_sys);
    wr(`TMR_OFF_CTRLB, 32'h0);
    rd(`TMR_OFF_FLAGS, 32'h0, "buffered compare a");
  endtask

  initial
  begin
    rst_n = 1'b0;
    extTick = 1'b0;
    ackOvf = 1'b0;
    ackA = 1'b0;
    ackB = 1'b0;
    nErrors = 0;
    checksDone = 0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    scnReset();
    scnOverflow();
    scnCompare();
    scnForce();
    scnBlock();
    scnCtc();
    scnBuffer();
    giveVerdict();
  end
endmodule
